// file: logic/ehds_sequencer.sv
// Purpose: Economizer, electric heat and heat pump defrost sequencing
// Assumes: Calls arrive from pins; sensors and config come from clk_sys logic
// Notes:   All timers step on one shared one-second tick
// What this block does
// (RULE1) Economizer runs only when enabled
// (RULE2) Config picks heat-content or dry-bulb sensor
// (RULE3) Heat-content setpoint choices A-E, default D
// (RULE4) Dry-bulb setpoint 20-105 F, default 63
// (RULE5) Good outdoor air opens damper, else mechanical
// (RULE6) Free cooling holds both compressors off
// (RULE7) Damper modulates supply air to 55 F
// (RULE8) Economizer only in cooling mode
// (RULE9) Stage two, force, changeover fault cancel economizer
// (RULE10) Supply fault cancels economizer; distinct fault codes
// (RULE11) Minimum position 20-100, 20 means closed
// (RULE12) Fan runs 10 s before heater
// (RULE13) Heater full on until request drops
// (RULE14) Fan purge after heat request ends
// (RULE15) Cooling plus heating keeps heater off
// (RULE16) Heat pump heat: both compressors, fans fixed
// (RULE17) Run timer accumulates; interval 30/60/90 min
// (RULE18) Interval end plus frozen coil starts defrost
// (RULE19) Defrost ends at 10 min or 70 F
// (RULE20) Unfinished defrost resumes on next call
// (RULE21) Coil sensor fault blocks heat pump compressors
// (RULE22) Heat during defrost unless interlocked or locked
// (RULE23) Outdoor sensor locks electric heat above setpoint
// (RULE24) Interlock keeps compressors off during heat call
// (RULE25) Fan speed follows highest priority request
// (RULE26) Timers use one prescaled one-second tick
// (RULE27) Sensors give reading and fault flag
`timescale 1ns/100ps
module ehds_sequencer
   import ehds_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
) (
   input  wire logic         clk_sys,
   input  wire logic         reset,
   input  wire ehds_calls_t  calls_pin,
   input  wire ehds_cfg_t    cfg,
   input  wire ehds_sensor_t enthalpy_sensor,
   input  wire ehds_sensor_t dry_bulb_sensor,
   input  wire ehds_sensor_t supply_air_sensor,
   input  wire ehds_sensor_t coil_frost_sensor,
   input  wire ehds_sensor_t outdoor_temp_lockout_sensor,
   output logic              compressor_one_relay_ff,
   output logic              compressor_two_relay_ff,
   output logic              reversing_valve_output_ff,
   output logic              heater_output_ff,
   output logic              outdoor_fan_max_ff,
   output logic              economizer_active_ff,
   output ehds_fan_t         fan_speed_ff,
   output logic [6:0]        damper_cmd_ff,
   output ehds_fault_t       fault_code_ff
);
   // ****************************************
   // Time base and input synchroniser
   // ****************************************
   logic [26:0]  tick_cnt_ff;  // Prescaler
   logic [26:0]  nxt_tick_cnt;
   logic         tick_ff;      // One-second pulse
   logic         nxt_tick;
   ehds_calls_t  sync1_ff;     // First stage, read only by second
   ehds_calls_t  calls_ff;     // Clean calls
   ehds_calls_t  nxt_sync1;
   ehds_calls_t  nxt_calls;

   // Prescaler wraps once a second
   always_comb begin
      nxt_tick     = 1'b0;
      nxt_tick_cnt = 27'(tick_cnt_ff + 1'b1);
      if (tick_cnt_ff == 27'(TICK_CYCLES - 1)) begin
         nxt_tick_cnt = '0;
         nxt_tick     = 1'b1; // RULE26
      end
      nxt_sync1 = calls_pin;
      nxt_calls = sync1_ff;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         tick_cnt_ff <= '0;
         tick_ff     <= 1'b0;
         sync1_ff    <= '0;
         calls_ff    <= '0;
      end else begin
         tick_cnt_ff <= nxt_tick_cnt;
         tick_ff     <= nxt_tick;
         sync1_ff    <= nxt_sync1;
         calls_ff    <= nxt_calls;
      end
   end

   // ****************************************
   // Mode decode
   // ****************************************
   logic         y1, y2, w2, rv_req;
   logic         cool_mode;    // Any cooling call; heat pump stage one only with the reversing valve request
   logic         hp_heat;      // Heat pump heating call
   ehds_sensor_t chg_sensor;   // Selected changeover sensor
   logic         chg_good;     // Outdoor air fit for free cooling
   logic         econ;         // Free cooling wanted
   logic         ods_ok;       // Outdoor lockout allows heat
   logic         lock_block;   // Heat interlock stops compressors

   assign y1     = calls_ff.cool_stage_one_call;
   assign y2     = calls_ff.cool_stage_two_call;
   assign w2     = calls_ff.electric_heat_call;
   assign rv_req = calls_ff.reversing_valve_request;
   // Heat pumps cool on stage one only with the reversing valve requested; stage two always cools
   assign cool_mode = y2 || (y1 && (!cfg.is_heat_pump || rv_req));
   assign hp_heat   = cfg.is_heat_pump && y1 && !rv_req && !y2;
   // The selected sensor's reading feeds the setpoint compare; its fault flag gates econ separately
   assign chg_sensor = cfg.dry_bulb_select ? dry_bulb_sensor : enthalpy_sensor; // RULE2 RULE27
   assign chg_good   = cfg.dry_bulb_select ?
                       (chg_sensor.temp_f < cfg.dry_bulb_setpoint) :          // RULE4
                       (chg_sensor.temp_f < ehds_en_setpoint(cfg.enthalpy_choice)); // RULE3
   // Any override hands cooling back to the compressors
   assign econ = cfg.econ_enable && cool_mode && chg_good                     // RULE1 RULE8
                 && !y2 && !calls_ff.force_compressor_input && !chg_sensor.fault // RULE9
                 && !supply_air_sensor.fault;                                 // RULE10
   // A missing or failed outdoor probe never blocks heat
   assign ods_ok = !cfg.ods_fitted || outdoor_temp_lockout_sensor.fault
                   || (outdoor_temp_lockout_sensor.temp_f < cfg.ods_setpoint); // RULE23
   assign lock_block = cfg.is_heat_pump && cfg.heat_compressor_interlock && w2; // RULE24

   // ****************************************
   // Timers
   // ****************************************
   typedef enum logic [1:0] {HT_IDLE, HT_PRE, HT_ON, HT_PURGE} ehds_ht_t;
   typedef enum logic {DF_ACCUM, DF_DEFROST} ehds_df_t;
   ehds_ht_t     ht_ff, nxt_ht;
   ehds_df_t     df_ff, nxt_df;
   logic [3:0]   pre_cnt;
   logic [7:0]   purge_cnt;
   logic [12:0]  acc_cnt;
   logic [9:0]   def_cnt;
   logic         acc_clr, def_clr;
   logic [12:0]  interval_s;

   ehds_sec_timer #(.W(4)) u_pre (
      .clk_sys(clk_sys), .reset(reset), .clear(ht_ff != HT_PRE),
      .run(ht_ff == HT_PRE), .tick(tick_ff), .count_ff(pre_cnt));
   ehds_sec_timer #(.W(8)) u_purge (
      .clk_sys(clk_sys), .reset(reset), .clear(ht_ff != HT_PURGE),
      .run(ht_ff == HT_PURGE), .tick(tick_ff), .count_ff(purge_cnt));
   ehds_sec_timer #(.W(13)) u_acc (
      .clk_sys(clk_sys), .reset(reset), .clear(acc_clr),
      .run(hp_heat && df_ff == DF_ACCUM), .tick(tick_ff), .count_ff(acc_cnt));
   ehds_sec_timer #(.W(10)) u_def (
      .clk_sys(clk_sys), .reset(reset), .clear(def_clr),
      .run(hp_heat && df_ff == DF_DEFROST), .tick(tick_ff), .count_ff(def_cnt));

   // ****************************************
   // Electric heat sequence
   // ****************************************
   // A new call during purge restarts the pre-run so the fan timing stays simple
   always_comb begin
      nxt_ht = ht_ff;
      unique case (ht_ff)
         HT_IDLE:  if (w2) nxt_ht = HT_PRE;
         HT_PRE: begin
            if (!w2) begin
               nxt_ht = HT_PURGE;
            end else if (pre_cnt >= PRERUN_S) begin
               nxt_ht = HT_ON;                                    // RULE12
            end
         end
         HT_ON:    if (!w2) nxt_ht = HT_PURGE;                    // RULE13
         HT_PURGE: begin
            if (w2) begin
               nxt_ht = HT_PRE;
            end else if (purge_cnt >= cfg.purge_secs) begin
               nxt_ht = HT_IDLE;                                  // RULE14
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ht_ff <= HT_IDLE;
      end else begin
         ht_ff <= nxt_ht;
      end
   end

   // ****************************************
   // Defrost sequence
   // ****************************************
   always_comb begin
      unique case (cfg.defrost_interval)
         2'h1:    interval_s = INT60_S;
         2'h2:    interval_s = INT90_S;
         default: interval_s = INT30_S;                           // RULE17
      endcase
      nxt_df  = df_ff;
      acc_clr = 1'b0;
      def_clr = 1'b0;
      unique case (df_ff)
         DF_ACCUM: begin
            if (acc_cnt >= interval_s) begin
               acc_clr = 1'b1;
               // A warm coil at interval end just restarts the count
               if (!coil_frost_sensor.fault && coil_frost_sensor.temp_f <= FREEZE_F) begin
                  nxt_df  = DF_DEFROST;                           // RULE18
                  def_clr = 1'b1;
               end
            end
         end
         DF_DEFROST: begin
            // Leaving the call keeps this state so the cycle resumes later
            if (hp_heat && (def_cnt >= DEF_MAX_S ||
                            coil_frost_sensor.temp_f >= THAW_F)) begin // RULE19 RULE20
               nxt_df = DF_ACCUM;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         df_ff <= DF_ACCUM;
      end else begin
         df_ff <= nxt_df;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   logic        def_active;   // Defrost running now
   logic        nxt_cc1, nxt_cc2, nxt_rv, nxt_heat, nxt_odf;
   ehds_fan_t   nxt_fan;
   logic [6:0]  nxt_dmp;
   logic [6:0]  min_pos;
   ehds_fault_t nxt_fault;

   assign def_active = (df_ff == DF_DEFROST) && hp_heat && !coil_frost_sensor.fault;

   always_comb begin
      // Clamp minimum position into the 2..10 V span
      min_pos = cfg.min_position;
      if (min_pos < DMP_MIN) min_pos = DMP_MIN;                   // RULE11
      if (min_pos > DMP_MAX) min_pos = DMP_MAX;
      // Compressors
      nxt_cc1 = 1'b0;
      nxt_cc2 = 1'b0;
      if (hp_heat) begin
         nxt_cc1 = !coil_frost_sensor.fault && !lock_block;       // RULE16 RULE21
         nxt_cc2 = !coil_frost_sensor.fault && !lock_block;
      end else if (cool_mode && !econ && !lock_block) begin
         nxt_cc1 = y1;                                            // RULE5
         nxt_cc2 = y2;
      end
      if (econ) begin
         nxt_cc1 = 1'b0;                                          // RULE6
         nxt_cc2 = 1'b0;
      end
      nxt_rv  = (cfg.is_heat_pump && cool_mode && rv_req) || def_active; // RULE18
      nxt_odf = hp_heat && !coil_frost_sensor.fault && !lock_block && !def_active;
      // Heater: never with cooling, defrost heat only without interlock
      nxt_heat = !cool_mode && ods_ok &&
                 ((ht_ff == HT_ON) ||
                  (def_active && cfg.heat_during_defrost_option &&
                   !cfg.heat_compressor_interlock));              // RULE15 RULE22
      // Fan speed by request priority
      if (y2) begin
         nxt_fan = FAN_Y2;                                        // RULE25
      end else if (y1) begin
         nxt_fan = hp_heat ? FAN_Y2 : FAN_Y1;
      end else if (ht_ff != HT_IDLE || w2) begin
         nxt_fan = FAN_W2;
      end else if (calls_ff.fan_only_call) begin
         nxt_fan = FAN_ONLY;
      end else begin
         nxt_fan = FAN_OFF;
      end
      // Damper: one 0.1 V step a second trades speed for a stable loop
      nxt_dmp = min_pos;
      if (econ) begin
         nxt_dmp = (damper_cmd_ff < min_pos) ? min_pos : damper_cmd_ff;
         if (tick_ff && supply_air_sensor.temp_f > SA_TARGET_F && nxt_dmp < DMP_MAX) begin
            nxt_dmp = 7'(nxt_dmp + 1'b1);                         // RULE7
         end else if (tick_ff && supply_air_sensor.temp_f < SA_TARGET_F &&
                      nxt_dmp > min_pos) begin
            nxt_dmp = 7'(nxt_dmp - 1'b1);
         end
      end
      // Display fault, most urgent first
      nxt_fault = FLT_NONE;
      if (cfg.is_heat_pump && coil_frost_sensor.fault) begin
         nxt_fault = FLT_COIL;                                    // RULE21
      end else if (cfg.econ_enable && supply_air_sensor.fault) begin
         nxt_fault = FLT_SUPPLY;                                  // RULE10
      end else if (cfg.econ_enable && chg_sensor.fault) begin
         nxt_fault = cfg.dry_bulb_select ? FLT_DRY_BULB : FLT_ENTHALPY;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         compressor_one_relay_ff   <= 1'b0;
         compressor_two_relay_ff   <= 1'b0;
         reversing_valve_output_ff <= 1'b0;
         heater_output_ff          <= 1'b0;
         outdoor_fan_max_ff        <= 1'b0;
         economizer_active_ff      <= 1'b0;
         fan_speed_ff              <= FAN_OFF;
         damper_cmd_ff             <= DMP_MIN;
         fault_code_ff             <= FLT_NONE;
      end else begin
         compressor_one_relay_ff   <= nxt_cc1;
         compressor_two_relay_ff   <= nxt_cc2;
         reversing_valve_output_ff <= nxt_rv;
         heater_output_ff          <= nxt_heat;
         outdoor_fan_max_ff        <= nxt_odf;
         economizer_active_ff      <= econ;
         fan_speed_ff              <= nxt_fan;
         damper_cmd_ff             <= nxt_dmp;
         fault_code_ff             <= nxt_fault;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   sequence s_heat_end;
      (ht_ff == HT_ON && w2) ##1 (ht_ff == HT_ON && !w2);
   endsequence
   property p_econ_cfg;   !cfg.econ_enable |=> !economizer_active_ff; endproperty
   property p_econ_cc;
      economizer_active_ff |-> !compressor_one_relay_ff && !compressor_two_relay_ff;
   endproperty
   property p_econ_cool;  economizer_active_ff |-> $past(cool_mode); endproperty
   property p_y2_cancel;  y2 |=> !economizer_active_ff; endproperty
   property p_prerun;
      (ht_ff == HT_PRE && !def_active) |=> !heater_output_ff;
   endproperty
   property p_cool_heat;  cool_mode |=> !heater_output_ff; endproperty
   property p_def_max;    (df_ff == DF_DEFROST) |-> def_cnt <= DEF_MAX_S; endproperty
   property p_coil_fault;
      (hp_heat && coil_frost_sensor.fault) |=> !compressor_one_relay_ff
                                               && !compressor_two_relay_ff;
   endproperty
   property p_purge;      s_heat_end |=> ht_ff == HT_PURGE ##1 fan_speed_ff != FAN_OFF; endproperty
   property p_min_pos;    !economizer_active_ff |-> damper_cmd_ff >= DMP_MIN; endproperty

   a_econ_cfg:   assert property (p_econ_cfg)   else $error("econ on while disabled"); // RULE1
   a_econ_cc:    assert property (p_econ_cc)    else $error("compressor in econ"); // RULE6
   a_econ_cool:  assert property (p_econ_cool)  else $error("econ outside cooling"); // RULE8
   a_y2_cancel:  assert property (p_y2_cancel)  else $error("stage two kept econ"); // RULE9
   a_prerun:     assert property (p_prerun)     else $error("heater during pre-run"); // RULE12
   a_cool_heat:  assert property (p_cool_heat)  else $error("heater with cooling"); // RULE15
   a_def_max:    assert property (p_def_max)    else $error("defrost overran"); // RULE19
   a_coil_fault: assert property (p_coil_fault) else $error("compressor on coil fault"); // RULE21
   a_purge:      assert property (p_purge)      else $error("fan stopped in purge"); // RULE14
   a_min_pos:    assert property (p_min_pos)    else $error("damper below closed"); // RULE11
endmodule : ehds_sequencer

// file: logic/ehds_pkg.sv
// Purpose: Shared types and constants for the economizer/heat/defrost sequencer
// Assumes: 125 MHz system clock; temperatures in whole degrees F
// Notes:   Heat-content readings arrive as equivalent dry-bulb F at 50% rh
package ehds_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int          CLK_HZ      = 125_000_000; // System clock rate
   localparam int          TICK_S      = 1;           // Time base period, seconds
   localparam int          TICK_CYC    = CLK_HZ * TICK_S;
   localparam logic [3:0]  PRERUN_S    = 4'hA;        // Fan pre-run before heater
   localparam logic [7:0]  PURGE_DEF_S = 8'h5A;       // Default fan purge, 90 s
   localparam int          DEF_MAX_MIN = 10;          // Longest defrost, minutes
   localparam logic [9:0]  DEF_MAX_S   = 10'(DEF_MAX_MIN * 60);
   localparam logic [12:0] INT30_S     = 13'(30 * 60); // Defrost intervals
   localparam logic [12:0] INT60_S     = 13'(60 * 60);
   localparam logic [12:0] INT90_S     = 13'(90 * 60);
   localparam logic [1:0]  INT_DEF     = 2'h0;        // Default interval, 30 min
   // ****************************************
   // Temperatures and positions
   // ****************************************
   localparam logic signed [7:0] SA_TARGET_F = 8'sh37; // 55 F supply target
   localparam logic signed [7:0] FREEZE_F    = 8'sh20; // 32 F coil freezing
   localparam logic signed [7:0] THAW_F      = 8'sh46; // 70 F defrost end
   localparam logic signed [7:0] DB_DEF_F    = 8'sh3F; // 63 F dry-bulb default
   localparam logic signed [7:0] DB_MIN_F    = 8'sh14; // 20 F
   localparam logic signed [7:0] DB_MAX_F    = 8'sh69; // 105 F
   localparam logic signed [7:0] ODS_DEF_F   = 8'sh32; // 50 F outdoor lockout
   localparam logic [2:0]  EN_DEF      = 3'h3;        // Choice D
   localparam logic [6:0]  DMP_MIN     = 7'h14;       // 20 = 2 V = closed
   localparam logic [6:0]  DMP_MAX     = 7'h64;       // 100 = 10 V = open
   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic cool_stage_one_call;
      logic cool_stage_two_call;
      logic electric_heat_call;
      logic reversing_valve_request;
      logic force_compressor_input;
      logic fan_only_call;
   } ehds_calls_t;
   typedef struct packed {
      logic signed [7:0] temp_f; // Reading, degrees F
      logic              fault;  // Open or faulty probe
   } ehds_sensor_t;
   typedef struct packed {
      logic              is_heat_pump;
      logic              econ_enable;
      logic              dry_bulb_select;
      logic [2:0]        enthalpy_choice;   // 0..4 = A..E
      logic signed [7:0] dry_bulb_setpoint;
      logic [6:0]        min_position;
      logic [7:0]        purge_secs;
      logic [1:0]        defrost_interval;  // 0/1/2 = 30/60/90 min
      logic              heat_during_defrost_option;
      logic              heat_compressor_interlock;
      logic              ods_fitted;
      logic signed [7:0] ods_setpoint;
   } ehds_cfg_t;
   typedef enum logic [2:0] {FAN_OFF, FAN_ONLY, FAN_W2, FAN_Y1, FAN_Y2} ehds_fan_t;
   typedef enum logic [2:0] {FLT_NONE, FLT_SUPPLY, FLT_ENTHALPY, FLT_DRY_BULB,
                             FLT_COIL} ehds_fault_t;
   // Heat-content changeover choices A..E, unknown codes fall to D
   function automatic logic signed [7:0] ehds_en_setpoint(input logic [2:0] c);
      case (c)
         3'h0:    ehds_en_setpoint = 8'sh49; // A 73 F
         3'h1:    ehds_en_setpoint = 8'sh46; // B 70 F
         3'h2:    ehds_en_setpoint = 8'sh43; // C 67 F
         3'h4:    ehds_en_setpoint = 8'sh37; // E 55 F
         default: ehds_en_setpoint = 8'sh3F; // D 63 F
      endcase
   endfunction : ehds_en_setpoint
endpackage : ehds_pkg

// file: logic/ehds_sec_timer.sv
// Purpose: Saturating seconds counter stepped by the shared time base
// Assumes: tick is a one-cycle pulse on clk_sys
// Notes:   Clear wins over counting
`timescale 1ns/100ps
module ehds_sec_timer #(
   parameter int W = 8
) (
   input  wire logic         clk_sys,
   input  wire logic         reset,
   input  wire logic         clear,
   input  wire logic         run,
   input  wire logic         tick,
   output logic [W-1:0]      count_ff
);
   logic [W-1:0] nxt_count; // Next count

   // Saturate so a long call never wraps back to a short time
   always_comb begin
      nxt_count = count_ff;
      if (clear) begin
         nxt_count = '0;
      end else if (run && tick && !(&count_ff)) begin
         nxt_count = W'(count_ff + 1'b1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         count_ff <= '0;
      end else begin
         count_ff <= nxt_count;
      end
   end
endmodule : ehds_sec_timer

// file: verif/ehds_partner.sv
// Purpose: Thermostat and supply air model facing the sequencer
// Assumes: Supply air cools as the damper opens
// Notes:   Calls are plain contacts; probe updates on falling edges
`timescale 1ns/100ps
module ehds_partner
   import ehds_pkg::*;
(
   input  wire logic         clk_sys,
   input  wire ehds_calls_t  calls_req,
   input  wire logic         sa_fault,
   input  wire logic [6:0]   damper_cmd_ff,
   output ehds_calls_t       calls_pin,
   output ehds_sensor_t      supply_air_sensor
);
   // Contacts follow the bench at once, so no extra edge of delay appears
   assign calls_pin = calls_req;
   // Probe reads 70 F closed and 30 F open; the falling edge avoids races
   always @(negedge clk_sys) begin
      supply_air_sensor.temp_f <= 8'sh50 - 8'(damper_cmd_ff >> 1);
      supply_air_sensor.fault  <= sa_fault;
   end
endmodule : ehds_partner

// file: verif/ehds_sequencer_tb_top.sv
// Purpose: Self-checking bench for the sequencer
// Assumes: Tick shortened to 10 clocks; minutes scale with it
// Notes:   Inputs change and outputs are read on falling edges
`timescale 1ns/100ps
module ehds_sequencer_tb_top
   import ehds_pkg::*;
;
   localparam int TK = 10;                         // Clocks per tick
   localparam logic signed [7:0] ENSP [5] = '{8'sh49, 8'sh46, 8'sh43, 8'sh3F, 8'sh37};
   logic         clk_sys = 1'b0;
   logic         reset   = 1'b1;
   ehds_calls_t  c, cp;                            // Requested and pin calls
   ehds_cfg_t    cfg;
   ehds_sensor_t en_s, db_s, sa_s, cf_s, od_s;
   logic         sa_flt, cc1, cc2, rv, ht, ofm, eco;
   ehds_fan_t    fan;
   logic [6:0]   dmp;
   ehds_fault_t  flt;
   int           bad_count = 0;
   int           check_count = 0;
   int           cyc = 0;
   ehds_partner i_ehds_partner (.clk_sys, .calls_req(c), .sa_fault(sa_flt),
      .damper_cmd_ff(dmp), .calls_pin(cp), .supply_air_sensor(sa_s));
   ehds_sequencer #(.TICK_CYCLES(TK)) i_ehds_sequencer (.clk_sys, .reset, .calls_pin(cp),
      .cfg, .enthalpy_sensor(en_s), .dry_bulb_sensor(db_s), .supply_air_sensor(sa_s),
      .coil_frost_sensor(cf_s), .outdoor_temp_lockout_sensor(od_s),
      .compressor_one_relay_ff(cc1), .compressor_two_relay_ff(cc2),
      .reversing_valve_output_ff(rv), .heater_output_ff(ht), .outdoor_fan_max_ff(ofm),
      .economizer_active_ff(eco), .fan_speed_ff(fan), .damper_cmd_ff(dmp),
      .fault_code_ff(flt));
   // *****************************
   // Clock, timeout and checks
   // *****************************
   initial forever #4 clk_sys = ~clk_sys;
   task automatic test_done;
      $display("checks %0d bad %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done
   // Run needs about 45k clocks; a hang is cut at the 60k budget
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         bad_count++;
         $display("BAD %0t timeout", $time);
         test_done();
      end
   end
   task automatic cyc_n(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : cyc_n
   task automatic ticks(input int n);
      cyc_n(n * TK);
   endtask : ticks
   // Calls need two sync edges plus one output edge, so four is safe
   task automatic call(input logic [5:0] v);
      c = v;
      cyc_n(4);
   endtask : call
   task automatic chk_bit(input logic g, input logic e, input string m);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %0t %s", $time, m);
      end
   endtask : chk_bit
   task automatic chk_fan(input ehds_fan_t g, input ehds_fan_t e, input string m);
      chk_bit(g === e, 1'b1, m);
   endtask : chk_fan
   task automatic chk_flt(input ehds_fault_t g, input ehds_fault_t e, input string m);
      chk_bit(g === e, 1'b1, m);
   endtask : chk_flt
   task automatic chk_dmp(input logic [6:0] g, input int lo, input int hi, input string m);
      chk_bit(g >= lo && g <= hi, 1'b1, m);
   endtask : chk_dmp
   task automatic no_econ(input string m);
      cyc_n(4);
      chk_bit(eco, 1'b0, m);
      chk_bit(cc1, 1'b1, m);
   endtask : no_econ
   // *****************************
   // Main sequence; call bits are y1 y2 w2 rv force fan
   // *****************************
   initial begin
      c = '0;
      sa_flt = 1'b0;
      cfg = '{1'b0, 1'b1, 1'b1, EN_DEF, DB_DEF_F, 7'h1E, 8'h05, INT_DEF, 1'b1, 1'b0,
              1'b0, ODS_DEF_F};
      en_s = '{8'sh32, 1'b0};
      db_s = '{8'sh32, 1'b0};
      cf_s = '{8'sh3C, 1'b0};
      od_s = '{8'sh3C, 1'b0};
      cyc_n(3);
      chk_bit(cc1 | cc2 | rv | ht | ofm | eco, 1'b0, "reset relays");
      chk_fan(fan, FAN_OFF, "reset fan");
      chk_dmp(dmp, 20, 20, "reset damper");
      chk_flt(flt, FLT_NONE, "reset fault");
      reset = 1'b0;
      call(6'b100000);
      chk_bit(eco, 1'b1, "free cooling");
      chk_bit(cc1 | cc2, 1'b0, "compressors locked");
      chk_fan(fan, FAN_Y1, "y1 fan");
      ticks(80);
      chk_dmp(dmp, 48, 53, "supply held at target");
      cfg.dry_bulb_select = 1'b0;
      db_s.temp_f = 8'sh5A;
      for (int i = 0; i < 5; i++) begin
         cfg.enthalpy_choice = 3'(i);
         en_s.temp_f = ENSP[i] - 8'sh01;
         cyc_n(2);
         chk_bit(eco, 1'b1, "below choice");
         en_s.temp_f = ENSP[i];
         cyc_n(2);
         chk_bit(eco, 1'b0, "at choice");
      end
      en_s.fault = 1'b1;
      cyc_n(2);
      chk_flt(flt, FLT_ENTHALPY, "heat code");
      cfg.dry_bulb_select = 1'b1;
      cfg.dry_bulb_setpoint = DB_MAX_F;
      db_s.temp_f = 8'sh68;
      cyc_n(2);
      chk_bit(eco, 1'b1, "below top setpoint");
      db_s.temp_f = DB_MAX_F;
      no_econ("hot outdoor");
      chk_dmp(dmp, 30, 30, "minimum position");
      db_s.temp_f = 8'sh32;
      c = 6'b110000;
      no_econ("stage two");
      chk_bit(cc2, 1'b1, "stage two relay");
      chk_fan(fan, FAN_Y2, "y2 fan");
      c = 6'b100010;
      no_econ("force input");
      c = 6'b100000;
      db_s.fault = 1'b1;
      no_econ("changeover fault");
      chk_flt(flt, FLT_DRY_BULB, "changeover code");
      db_s.fault = 1'b0;
      sa_flt = 1'b1;
      no_econ("supply fault");
      chk_flt(flt, FLT_SUPPLY, "supply code");
      sa_flt = 1'b0;
      cfg.econ_enable = 1'b0;
      no_econ("disabled");
      cfg.econ_enable = 1'b1;
      call(6'b001000);
      chk_fan(fan, FAN_W2, "pre-run fan");
      chk_bit(eco, 1'b0, "no econ in heat");
      ticks(8);
      chk_bit(ht, 1'b0, "heater waits");
      ticks(4);
      chk_bit(ht, 1'b1, "heater on");
      call(6'b101000);
      chk_bit(ht, 1'b0, "cool with heat");
      chk_fan(fan, FAN_Y1, "cool over heat");
      c = 6'b001000;
      cfg.ods_fitted = 1'b1;
      cyc_n(4);
      chk_bit(ht, 1'b0, "outdoor lock");
      cfg.ods_fitted = 1'b0;
      call(6'b000000);
      chk_bit(ht, 1'b0, "heater off");
      ticks(3);
      chk_fan(fan, FAN_W2, "purge runs");
      ticks(4);
      chk_fan(fan, FAN_OFF, "purge ends");
      call(6'b000001);
      chk_fan(fan, FAN_ONLY, "fan only");
      cfg.is_heat_pump = 1'b1;
      cf_s = '{8'sh14, 1'b1};
      call(6'b100000);
      chk_bit(cc1, 1'b0, "coil fault blocks");
      chk_flt(flt, FLT_COIL, "coil code");
      cf_s.fault = 1'b0;
      cyc_n(2);
      chk_bit(cc1 & cc2 & ofm, 1'b1, "heat pump heat");
      chk_fan(fan, FAN_Y2, "heat pump fan");
      ticks(1790);
      chk_bit(rv, 1'b0, "interval running");
      ticks(15);
      chk_bit(rv & cc1 & ~ofm, 1'b1, "defrost");
      chk_bit(ht, 1'b1, "heat in defrost");
      cf_s.temp_f = THAW_F;
      cyc_n(3);
      chk_bit(rv, 1'b0, "thawed");
      cf_s.temp_f = 8'sh14;
      ticks(1805);
      chk_bit(rv, 1'b1, "second defrost");
      ticks(100);
      call(6'b000000);
      ticks(5);
      call(6'b100000);
      chk_bit(rv, 1'b1, "defrost resumed");
      ticks(480);
      chk_bit(rv, 1'b1, "defrost before limit");
      ticks(30);
      chk_bit(rv, 1'b0, "defrost limit");
      cfg.heat_compressor_interlock = 1'b1;
      call(6'b101000);
      chk_bit(cc1 | cc2, 1'b0, "interlock");
      test_done();
   end
endmodule : ehds_sequencer_tb_top
